// ==== logic/ccdrs_pkg.sv ====
// constants for the area ccd readout sequencer
package ccdrs_pkg;
  // clock
  localparam int CLOCK_NS = 50;
  // vertical transfer pulse width and transfer/horizontal overlap, in ns
  localparam int VERT_PW_NS = 18000;
  localparam int VERT_PW_MIN_NS = 6000;
  localparam int OVERLAP_NS = 6000;
  localparam int OVERLAP_MIN_NS = 3000;
  // horizontal and summing gate pulse width, reset gate pulse width, in ns
  localparam int HORIZ_PW_NS = 5000;
  localparam int HORIZ_PW_MIN_NS = 500;
  localparam int RESET_PW_NS = 500;
  localparam int RESET_PW_MIN_NS = 100;
  // fastest allowed pixel period (1 MHz)
  localparam int PIXEL_PERIOD_MIN_NS = 1000;
  // cycle counts, typical times rounded up
  localparam int VERT_CYC_I = (VERT_PW_NS + CLOCK_NS - 1) / CLOCK_NS;
  localparam int OVERLAP_CYC_I = (OVERLAP_NS + CLOCK_NS - 1) / CLOCK_NS;
  localparam int HORIZ_CYC_I = (HORIZ_PW_NS + CLOCK_NS - 1) / CLOCK_NS;
  localparam int RESET_CYC_I = (RESET_PW_NS + CLOCK_NS - 1) / CLOCK_NS;
  localparam int VERT_TWO_CYC_I = (VERT_CYC_I > OVERLAP_CYC_I) ? VERT_CYC_I : OVERLAP_CYC_I;
  localparam logic [8:0] VERT_ONE_CYC = VERT_CYC_I[8:0];
  localparam logic [8:0] VERT_TWO_CYC = VERT_TWO_CYC_I[8:0];
  localparam logic [8:0] HORIZ_HALF_CYC = HORIZ_CYC_I[8:0];
  localparam logic [8:0] RESET_CYC = RESET_CYC_I[8:0];
  // horizontal line layout, left to right
  localparam int H_BLANK_L = 4;
  localparam int H_BLACK_L = 4;
  localparam int H_ISO_L = 4;
  localparam int H_EFFECTIVE = 1024;
  localparam int H_ISO_R = 4;
  localparam int H_BLACK_R = 0;
  localparam int H_BLANK_R = 4;
  localparam int H_TOTAL_I = H_BLANK_L + H_BLACK_L + H_ISO_L + H_EFFECTIVE
                           + H_ISO_R + H_BLACK_R + H_BLANK_R;
  localparam int H_EFF_FIRST_I = H_BLANK_L + H_BLACK_L + H_ISO_L;
  localparam int H_BLACK_FIRST_I = H_BLANK_L;
  // vertical frame layout, top to bottom
  localparam int V_ISO_T = 4;
  localparam int V_EFFECTIVE = 1024;
  localparam int V_ISO_B = 4;
  localparam int V_TOTAL_I = V_ISO_T + V_EFFECTIVE + V_ISO_B;
  localparam logic [10:0] H_LAST = 11'(H_TOTAL_I - 1);
  localparam logic [10:0] H_EFF_FIRST = 11'(H_EFF_FIRST_I);
  localparam logic [10:0] H_EFF_LAST = 11'(H_EFF_FIRST_I + H_EFFECTIVE - 1);
  localparam logic [10:0] H_BLACK_FIRST = 11'(H_BLACK_FIRST_I);
  localparam logic [10:0] H_BLACK_LAST = 11'(H_BLACK_FIRST_I + H_BLACK_L - 1);
  localparam logic [10:0] V_LAST = 11'(V_TOTAL_I - 1);
  localparam logic [10:0] V_EFF_FIRST = 11'(V_ISO_T);
  localparam logic [10:0] V_EFF_LAST = 11'(V_ISO_T + V_EFFECTIVE - 1);
  // sequencer states
  typedef enum logic [2:0] {
    CCDRS_IDLE,
    CCDRS_VERT_ONE,
    CCDRS_VERT_TWO,
    CCDRS_HORIZ_FIRST,
    CCDRS_HORIZ_SECOND
  } ccdrs_state_t;
endpackage

// ==== logic/ccdrs_timer.sv ====
// phase timer: counts cycles within one phase and flags the last one
`timescale 1ns/10ps
`default_nettype none
module ccdrs_timer (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst,
  // control
  input  wire logic       clear,
  input  wire logic [8:0] limit,
  // status
  output logic      [8:0] count,
  output logic            last
);
  import ccdrs_pkg::*;

  typedef struct packed {
    logic [8:0] count;
  } ccdrs_timer_state_t;

  ccdrs_timer_state_t cur;
  ccdrs_timer_state_t next_cur;

  // last cycle of the phase; the count wraps by itself so phases chain without gaps
  assign last  = (cur.count == (limit - 9'h001));
  assign count = cur.count;

  // next count
  always_comb begin
    next_cur = cur;
    if (clear || last) begin
      next_cur.count = 9'h000;
    end else begin
      next_cur.count = cur.count + 9'h001;
    end
  end

  // state register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end
endmodule // ccdrs_timer
`default_nettype wire

// ==== logic/ccdrs_sequencer.sv ====
// clock sequencer driving a 1024 x 1024 full-frame area ccd
`timescale 1ns/10ps
`default_nettype none
module ccdrs_sequencer (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // frame control
  // busy and frame_done let a host pace frames without timing them itself
  input  wire logic        start,
  input  wire logic        continuous,
  output logic             busy,
  output logic             frame_done,
  // sensor clocks and gates
  output logic             vertical_phase_one,
  output logic             vertical_phase_two,
  output logic             transfer_isolation_gate,
  output logic             horizontal_phase_one,
  output logic             horizontal_phase_two,
  output logic             summing_gate,
  output logic             output_reset_gate,
  // sample strobe for the converter watching output_source
  // column and row name the pixel just dumped and hold until the next strobe
  // effective and black flag the pixel class, so the converter needs no table
  output logic             sample_strobe,
  output logic      [10:0] sample_column,
  output logic      [10:0] sample_row,
  output logic             sample_effective,
  output logic             sample_black
);
  import ccdrs_pkg::*;

  // all state but the timer count sits in one record, so reset and registering cover it in one go
  // sensor pin levels are stored, not decoded from the state, so every sensor pin leaves a flop
  // a decoded pin could glitch, and the clock drivers would pass the runt on
  typedef struct packed {
    ccdrs_state_t state;
    logic [10:0]  col;
    logic [10:0]  row;
    logic         v_one;
    logic         v_two;
    logic         h_one;
    logic         h_two;
    logic         reset_gate;
    logic         strobe;
    logic [10:0]  s_col;
    logic [10:0]  s_row;
    logic         s_eff;
    logic         s_black;
    logic         done;
  } ccdrs_seq_state_t;

  ccdrs_seq_state_t cur;
  ccdrs_seq_state_t next_cur;
  logic [8:0]       limit;
  logic [8:0]       count;
  logic             last;
  logic             timer_clear;

  // phase length per state; both horizontal halves equal gives the 50 percent duty
  // each length is the typical width, far above the least one, so slow driver
  // edges on the large vertical load still leave the sensor a full pulse
  // idle keeps a harmless length, the timer is held clear there anyway
  always_comb begin
    limit = HORIZ_HALF_CYC;
    unique case (cur.state)
      CCDRS_IDLE:         limit = HORIZ_HALF_CYC;
      CCDRS_VERT_ONE:     limit = VERT_ONE_CYC;
      CCDRS_VERT_TWO:     limit = VERT_TWO_CYC;
      CCDRS_HORIZ_FIRST:  limit = HORIZ_HALF_CYC;
      CCDRS_HORIZ_SECOND: limit = HORIZ_HALF_CYC;
    endcase
  end

  // timer held at zero while idle so the first phase gets its full length
  // this also drops any count left over when reset cut a frame part way
  // and a start in idle always sees a fresh phase, never a stale one
  assign timer_clear = (cur.state == CCDRS_IDLE);

  // one timer serves every phase, since only one phase runs at a time
  // it wraps by itself at the limit, so state change and restart share an edge
  ccdrs_timer u_timer (
    .clock (clock),
    .rst   (rst),
    .clear (timer_clear),
    .limit (limit),
    .count (count),
    .last  (last)
  );

  // sequencing: transfer one row, then shift out every position of it
  // one row, in cycles after the edge that starts it:
  //   0 to 359     first vertical phase
  //   360 to 719   second vertical phase and transfer gate, first horizontal
  //                phase already high so the line lands in the horizontal register
  //   720 to 819   first horizontal phase of column 0
  //   820 to 919   second horizontal phase and summing gate of column 0
  //   821 to 830   reset gate clears the output node
  //   920          summing gate falls, strobe marks column 0
  // every later column repeats this 200 cycle pixel, 10 us or 0.1 MHz
  // after the last column the next row's first vertical phase starts at once
  // columns 0-3 blank, 4-7 optical black, 8-11 isolation, 12-1035 effective,
  // 1036-1039 isolation, 1040-1043 blank; the right black group is empty
  // rows 0-3 and 1028-1031 are isolation, rows 4-1027 effective
  // a frame is 1032 rows of 1044 positions, a little over 216 million cycles
  // start counts only in idle; a start while busy is dropped without a trace
  // continuous counts only at the end of the last pixel of a frame
  // limitation: there is no abort, only reset stops a frame part way
  always_comb begin
    next_cur        = cur;
    next_cur.strobe = 1'b0;
    next_cur.done   = 1'b0;
    unique case (cur.state)
      CCDRS_IDLE: begin
        // start may be a level or a pulse; only its value at this edge counts
        if (start) begin
          next_cur.state = CCDRS_VERT_ONE;
          next_cur.row   = 11'h000;
          next_cur.col   = 11'h000;
        end
      end
      CCDRS_VERT_ONE: begin
        // the whole image moves down one row during this phase
        if (last) begin
          next_cur.state = CCDRS_VERT_TWO;
        end
      end
      CCDRS_VERT_TWO: begin
        // the column count restarts while the line is still moving down
        if (last) begin
          next_cur.state = CCDRS_HORIZ_FIRST;
          next_cur.col   = 11'h000;
        end
      end
      CCDRS_HORIZ_FIRST: begin
        // charge of this column sits under the first horizontal phase
        if (last) begin
          next_cur.state = CCDRS_HORIZ_SECOND;
        end
      end
      CCDRS_HORIZ_SECOND: begin
        if (last) begin
          // summing gate falls here and dumps the pixel onto the output node
          next_cur.strobe  = 1'b1;
          next_cur.s_col   = cur.col;
          next_cur.s_row   = cur.row;
          next_cur.s_eff   = (cur.col >= H_EFF_FIRST) && (cur.col <= H_EFF_LAST) &&
                             (cur.row >= V_EFF_FIRST) && (cur.row <= V_EFF_LAST);
          next_cur.s_black = (cur.col >= H_BLACK_FIRST) && (cur.col <= H_BLACK_LAST);
          if (cur.col != H_LAST) begin
            next_cur.col   = cur.col + 11'h001;
            next_cur.state = CCDRS_HORIZ_FIRST;
          end else if (cur.row != V_LAST) begin
            next_cur.row   = cur.row + 11'h001;
            next_cur.state = CCDRS_VERT_ONE;
          end else begin
            next_cur.done  = 1'b1;
            next_cur.row   = 11'h000;
            next_cur.state = continuous ? CCDRS_VERT_ONE : CCDRS_IDLE;
          end
        end
      end
    endcase
    // pin levels follow the next state so they change on the phase edge itself
    // decoding the next state costs a little logic but saves a cycle of lag,
    // which would otherwise put every pin one cycle behind its phase
    next_cur.v_one = (next_cur.state == CCDRS_VERT_ONE);
    next_cur.v_two = (next_cur.state == CCDRS_VERT_TWO);
    // first horizontal phase stays high across the whole transfer-gate pulse
    next_cur.h_one = (next_cur.state == CCDRS_VERT_TWO) ||
                     (next_cur.state == CCDRS_HORIZ_FIRST);
    next_cur.h_two = (next_cur.state == CCDRS_HORIZ_SECOND);
    // reset pulse trails the summing gate rise by one cycle and ends well before its fall
    // the node is cleared early so the output has about 90 cycles to settle
    next_cur.reset_gate = (cur.state == CCDRS_HORIZ_SECOND) && (count < RESET_CYC);
  end

  // state register
  // async reset parks every pin low, which the sensor takes as all clocks off
  // the reset branch loads a constant only, so release is clean on any edge
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cur <= '{state: CCDRS_IDLE, default: '0};
    end else begin
      cur <= next_cur;
    end
  end

  // outputs; gate copies share the flip-flop so they cannot skew by a cycle
  // the isolation gate must match the second vertical phase exactly, so it
  // reuses that flop instead of a twin that could drift apart later
  assign vertical_phase_one      = cur.v_one;
  assign vertical_phase_two      = cur.v_two;
  assign transfer_isolation_gate = cur.v_two;
  assign horizontal_phase_one    = cur.h_one;
  assign horizontal_phase_two    = cur.h_two;
  assign summing_gate            = cur.h_two;
  assign output_reset_gate       = cur.reset_gate;
  assign sample_strobe           = cur.strobe;
  assign sample_column           = cur.s_col;
  assign sample_row              = cur.s_row;
  assign sample_effective        = cur.s_eff;
  assign sample_black            = cur.s_black;
  assign busy                    = (cur.state != CCDRS_IDLE);
  assign frame_done              = cur.done;
endmodule // ccdrs_sequencer
`default_nettype wire

// ==== tb/ccdrs_chk.sv ====
// assertion checker for the ccd readout sequencer ports
`timescale 1ns/10ps
`default_nettype none
module ccdrs_chk (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // watched ports
  input wire logic start,
  input wire logic busy,
  input wire logic vertical_phase_one,
  input wire logic vertical_phase_two,
  input wire logic transfer_isolation_gate,
  input wire logic horizontal_phase_one,
  input wire logic horizontal_phase_two,
  input wire logic summing_gate,
  input wire logic output_reset_gate,
  input wire logic sample_strobe
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  logic [8:0] v1_len, v2_len, h2_len, reset_len, gap;
  // high run lengths; gap saturates so long row ends never wrap
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      {v1_len, v2_len, h2_len, reset_len} <= '0;
      gap <= 9'h1FF;
    end else begin
      v1_len <= vertical_phase_one ? v1_len + 9'h001 : 9'h000;
      v2_len <= vertical_phase_two ? v2_len + 9'h001 : 9'h000;
      h2_len <= horizontal_phase_two ? h2_len + 9'h001 : 9'h000;
      reset_len <= output_reset_gate ? reset_len + 9'h001 : 9'h000;
      gap <= sample_strobe ? 9'h001 : (gap == 9'h1FF) ? gap : gap + 9'h001;
    end
  end
  iso_copy_a: assert property (transfer_isolation_gate == vertical_phase_two)
    else $error("isolation gate differs from second vertical phase");
  sum_copy_a: assert property (summing_gate == horizontal_phase_two)
    else $error("summing gate differs from second horizontal phase");
  phase_pair_a: assert property (!(vertical_phase_one && vertical_phase_two)
    && !(horizontal_phase_one && horizontal_phase_two)) else $error("phases overlap");
  v1_width_a: assert property ($fell(vertical_phase_one) |-> v1_len == 9'h168)
    else $error("first vertical phase width wrong");
  iso_overlap_a: assert property ($fell(vertical_phase_two) |-> v2_len == 9'h168
    && horizontal_phase_one) else $error("transfer overlap wrong");
  h2_width_a: assert property ($fell(horizontal_phase_two) |-> h2_len == 9'h064)
    else $error("horizontal pulse width wrong");
  reset_width_a: assert property ($fell(output_reset_gate) |-> reset_len == 9'h00A)
    else $error("reset gate width wrong");
  reset_order_a: assert property ($rose(summing_gate) |=> $rose(output_reset_gate)
    ##10 (!output_reset_gate && summing_gate)) else $error("reset gate misplaced");
  pixel_rate_a: assert property (sample_strobe && gap != 9'h1FF |-> gap == 9'h0C8)
    else $error("pixel period wrong");
  dump_strobe_a: assert property ($fell(summing_gate) |-> sample_strobe)
    else $error("strobe not at charge dump");
  start_ans_a: assert property (start && !busy |=> busy && vertical_phase_one)
    else $error("start not answered");
  cover property ($fell(vertical_phase_two));
  cover property (sample_strobe);
  cover property (start && busy);
endmodule // ccdrs_chk
bind ccdrs_sequencer ccdrs_chk u_chk (.clock(clock), .rst(rst), .start(start), .busy(busy),
  .vertical_phase_one(vertical_phase_one), .vertical_phase_two(vertical_phase_two),
  .transfer_isolation_gate(transfer_isolation_gate),
  .horizontal_phase_one(horizontal_phase_one), .horizontal_phase_two(horizontal_phase_two),
  .summing_gate(summing_gate), .output_reset_gate(output_reset_gate),
  .sample_strobe(sample_strobe));
`default_nettype wire

// ==== tb/ccdrs_sensor_model.sv ====
// sensor model: counts charge dumps per line and rows per frame
`timescale 1ns/10ps
`default_nettype none
module ccdrs_sensor_model
  import ccdrs_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // gates from the sequencer
  input wire logic vertical_phase_one,
  input wire logic summing_gate,
  input wire logic output_reset_gate,
  // counts seen by the sensor
  output logic [10:0] dumps,
  output logic [10:0] rows,
  output logic bad
);
  logic prev_v1, prev_sum, reset_seen;
  // a dump without a fresh reset pulse would mix two pixels' charge
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      {prev_v1, prev_sum, reset_seen, bad, dumps, rows} <= '0;
    end else begin
      prev_v1 <= vertical_phase_one;
      prev_sum <= summing_gate;
      if (output_reset_gate) reset_seen <= 1'b1;
      if (prev_sum && !summing_gate) begin
        dumps <= dumps + 11'h001;
        reset_seen <= 1'b0;
        if (!reset_seen) bad <= 1'b1;
      end
      if (vertical_phase_one && !prev_v1) begin
        dumps <= 11'h000;
        rows <= (rows == V_LAST) ? 11'h000 : rows + 11'h001;
        if (dumps != 11'h000 && dumps != H_LAST + 11'h001) bad <= 1'b1;
      end
    end
  end
endmodule // ccdrs_sensor_model
`default_nettype wire

// ==== tb/ccd_area_readout_sequencer_tb_top.sv ====
// testbench for the ccd readout sequencer
`timescale 1ns/10ps
`default_nettype none
module ccd_area_readout_sequencer_tb_top;
  import ccdrs_pkg::*;
  logic clock, rst, start, continuous, busy, frame_done, v1, v2, iso_gate, h1, h2;
  logic sum_gate, reset_gate;
  logic strobe, eff, blk, bad;
  logic [10:0] col, row, dumps, rows;
  int num_errors, checks_done, seed;
  ccdrs_sequencer dut (.clock(clock), .rst(rst), .start(start), .continuous(continuous),
    .busy(busy), .frame_done(frame_done), .vertical_phase_one(v1), .vertical_phase_two(v2),
    .transfer_isolation_gate(iso_gate), .horizontal_phase_one(h1), .horizontal_phase_two(h2),
    .summing_gate(sum_gate), .output_reset_gate(reset_gate), .sample_strobe(strobe),
    .sample_column(col), .sample_row(row), .sample_effective(eff), .sample_black(blk));
  ccdrs_sensor_model sensor (.clock(clock), .rst(rst), .vertical_phase_one(v1),
    .summing_gate(sum_gate), .output_reset_gate(reset_gate), .dumps(dumps), .rows(rows),
    .bad(bad));
  // clock at 20 MHz
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  task automatic cmp_bit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_idx(input logic [10:0] got, input logic [10:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    if (num_errors == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // settle 1 ns past the edge so registered outputs have landed
  task automatic edges(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  function automatic logic exp_black(input int c);
    return c >= H_BLANK_L && c < H_BLANK_L + H_BLACK_L;
  endfunction
  // first part of a row; starts issued while busy must change nothing
  task automatic run_row(input int n);
    @(posedge clock) start <= 1'b1;
    @(posedge clock) start <= 1'b0;
    #1;
    cmp_bit(v1 & busy, 1'b1);
    edges(359);
    cmp_bit(v1, 1'b1);
    edges(1);
    cmp_bit(v1 | ~v2 | ~h1 | ~iso_gate, 1'b0);
    edges(360);
    cmp_bit(v2 | ~h1, 1'b0);
    edges(101);
    cmp_bit(reset_gate & h2 & sum_gate, 1'b1);
    edges(99);
    for (int c = 0; c < n; c++) begin
      cmp_bit(strobe, 1'b1);
      cmp_idx(col, 11'(c));
      cmp_idx(dumps, 11'(c));
      cmp_bit(blk, exp_black(c));
      cmp_bit(eff, 1'b0);
      cmp_bit(frame_done, 1'b0);
      cmp_idx(row | (rows ^ 11'h001), 11'h000);
      @(posedge clock) start <= 1'($random(seed));
      continuous <= 1'($random(seed));
      edges(199);
    end
    @(posedge clock) start <= 1'b0;
  endtask
  // watchdog: two rows of checks take about 64500 cycles
  initial begin
    #3500000;
    num_errors++;
    conclude();
  end
  initial begin
    seed = 32'hECD1;
    {rst, start, continuous, num_errors, checks_done} = {1'b1, 2'b00, 64'h0};
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    run_row(300);
    @(posedge clock) rst <= 1'b1;
    edges(2);
    cmp_bit(busy | v1 | h1 | strobe | frame_done | reset_gate, 1'b0);
    cmp_idx(col | dumps, 11'h000);
    @(posedge clock) rst <= 1'b0;
    run_row(13);
    cmp_bit(bad, 1'b0);
    conclude();
  end
endmodule // ccd_area_readout_sequencer_tb_top
`default_nettype wire
